// file: src/tmr_pkg.sv
// constants and types shared by the split-capable timer
// Functional notes
// - timing, capture/compare and pwm in 32-bit use
// - split option gives two independent 16-bit counters
// - capture, pin and pwm only when not split
// - one-shot and continuous auto-reload counting modes
// - programmable prescaler divides the counting clock
// - pin selectable as timer input or output
// - output pin shows pwm or rollover toggle
// - input pin counts, gates clock or captures
package tmr_pkg;
    localparam logic [7:0] off_ctrl = 8'h00;
    localparam logic [7:0] off_presc = 8'h04;
    localparam logic [7:0] off_count = 8'h08;
    localparam logic [7:0] off_limit = 8'h0c;
    localparam logic [7:0] off_cmp = 8'h10;
    localparam logic [7:0] off_capt = 8'h14;
    localparam logic [7:0] off_status = 8'h18;
    localparam logic [7:0] off_mask = 8'h1c;

    localparam int bit_en_a = 0;
    localparam int bit_cont_a = 1;
    localparam int bit_split = 2;
    localparam int bit_en_b = 3;
    localparam int bit_cont_b = 4;
    localparam int pos_pin = 5;

    localparam int bit_roll_a = 0;
    localparam int bit_event = 1;
    localparam int bit_roll_b = 2;

    localparam logic [31:0] rst_ctrl = 32'h0000_0000;
    localparam logic [31:0] rst_presc = 32'h0000_0000;
    localparam logic [31:0] rst_limit = 32'hffff_ffff;
    localparam logic [31:0] rst_cmp = 32'h0000_0000;
    localparam logic [2:0] rst_mask = 3'h0;

    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef enum logic [2:0] {
        pin_off = 3'b000,
        pin_pwm = 3'b001,
        pin_roll = 3'b010,
        pin_count = 3'b011,
        pin_gate = 3'b100,
        pin_capture = 3'b101
    } pin_mode_t;
endpackage

// file: src/tmr_prescaler.sv
// clock prescaler giving a one-cycle count enable
`timescale 1ns/100ps
module tmr_prescaler #(
    parameter int width = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [width-1:0] div,
    output logic tick
);
    logic [width-1:0] cnt;

    // divides by div+1; div of zero ticks every cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (cnt >= div) begin
            cnt <= '0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    presc_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && div != '0 && $stable(div) |=> !tick)
        else $error("prescaler ticked twice in a row");
endmodule

// file: src/tmr_unit.sv
// split-capable 32-bit timer with axi4-lite registers and pin function
`timescale 1ns/100ps
module tmr_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    output logic irq
);
    import tmr_pkg::*;

    logic [31:0] ctrl;
    logic [31:0] presc;
    logic [31:0] cnt;
    logic [31:0] limit;
    logic [31:0] cmp;
    logic [31:0] capt;
    logic [2:0] status;
    logic [2:0] mask;

    // ---------------- axi4-lite write side
    logic aw_held;
    logic w_held;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] s_q;
    logic wr_go;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_go = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
    assign wa = aw_held ? aw_q : s_axi_awaddr;
    assign wd = w_held ? w_q : s_axi_wdata;
    assign ws = w_held ? s_q : s_axi_wstrb;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // address and data may come in either order; held until the pair is done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            s_q <= 4'h0;
        end else if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_q <= s_axi_wdata;
                s_q <= s_axi_wstrb;
            end
        end
    end

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= off_mask;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wa) ? resp_okay : resp_slverr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_ctrl;
    logic wr_cnt;
    assign wr_ctrl = wr_go && wa == off_ctrl;
    assign wr_cnt = wr_go && wa == off_count;

    // ---------------- axi4-lite read side
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= resp_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? resp_okay : resp_slverr;
            unique case (s_axi_araddr)
                off_ctrl: s_axi_rdata <= ctrl;
                off_presc: s_axi_rdata <= presc;
                off_count: s_axi_rdata <= cnt;
                off_limit: s_axi_rdata <= limit;
                off_cmp: s_axi_rdata <= cmp;
                off_capt: s_axi_rdata <= capt;
                off_status: s_axi_rdata <= {29'h0, status};
                off_mask: s_axi_rdata <= {29'h0, mask};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- pin synchroniser
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic pin_rise;

    // the pin must stay under a quarter of aclk so no edge slips past
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end else begin
            pin_s1 <= pin_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    assign pin_rise = pin_s2 && !pin_s3;

    // ---------------- mode decode
    logic split;
    logic en_a;
    logic en_b;
    pin_mode_t pmode;
    logic pin_live;

    assign split = ctrl[bit_split];
    assign en_a = ctrl[bit_en_a];
    assign en_b = ctrl[bit_en_b];
    assign pmode = pin_mode_t'(ctrl[pos_pin +: 3]);
    assign pin_live = !split;

    // ---------------- prescalers and count enables
    logic pre_a;
    logic pre_b;
    logic tick_a;

    tmr_prescaler #(.width(16)) u_pre_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .div(presc[15:0]),
        .tick(pre_a)
    );

    tmr_prescaler #(.width(16)) u_pre_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .div(presc[31:16]),
        .tick(pre_b)
    );

    always_comb begin
        tick_a = pre_a;
        if (pin_live && pmode == pin_count) begin
            tick_a = pin_rise;
        end else if (pin_live && pmode == pin_gate) begin
            tick_a = pre_a && pin_s2;
        end
    end

    logic step_a;
    logic step_b;
    logic hit_a;
    logic hit_b;
    logic roll_a;
    logic roll_b;

    assign step_a = en_a && tick_a;
    assign step_b = split && en_b && pre_b;
    assign hit_a = split ? cnt[15:0] == limit[15:0] : cnt == limit;
    assign hit_b = cnt[31:16] == limit[31:16];
    assign roll_a = step_a && hit_a;
    assign roll_b = step_b && hit_b;

    // ---------------- counter
    // a software write of the count overrides any step in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 32'h0000_0000;
        end else if (wr_cnt) begin
            cnt <= merge(cnt, wd, ws);
        end else if (split) begin
            if (step_a) begin
                cnt[15:0] <= hit_a ? 16'h0000 : cnt[15:0] + 16'h0001;
            end
            if (step_b) begin
                cnt[31:16] <= hit_b ? 16'h0000 : cnt[31:16] + 16'h0001;
            end
        end else if (step_a) begin
            cnt <= hit_a ? 32'h0000_0000 : cnt + 32'h0000_0001;
        end
    end

    // ---------------- control and setup registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= rst_ctrl;
        end else if (wr_ctrl) begin
            ctrl <= merge(ctrl, wd, ws);
        end else begin
            if (roll_a && !ctrl[bit_cont_a]) begin
                ctrl[bit_en_a] <= 1'b0;
            end
            if (roll_b && !ctrl[bit_cont_b]) begin
                ctrl[bit_en_b] <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc <= rst_presc;
            limit <= rst_limit;
            cmp <= rst_cmp;
            mask <= rst_mask;
        end else if (wr_go) begin
            if (wa == off_presc) begin
                presc <= merge(presc, wd, ws);
            end
            if (wa == off_limit) begin
                limit <= merge(limit, wd, ws);
            end
            if (wa == off_cmp) begin
                cmp <= merge(cmp, wd, ws);
            end
            if (wa == off_mask && ws[0]) begin
                mask <= wd[2:0];
            end
        end
    end

    // ---------------- capture and compare
    logic cap_ev;
    logic cmp_ev;

    assign cap_ev = pin_live && pmode == pin_capture && pin_rise;
    assign cmp_ev = pin_live && pmode == pin_pwm && step_a && cnt == cmp;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capt <= 32'h0000_0000;
        end else if (cap_ev) begin
            capt <= cnt;
        end
    end

    // ---------------- pin output
    logic pin_out_mode;
    assign pin_out_mode = pmode == pin_pwm || pmode == pin_roll;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= pin_live && pin_out_mode;
            if (!pin_live || !pin_out_mode) begin
                pin_o <= 1'b0;
            end else if (pmode == pin_pwm) begin
                pin_o <= cnt < cmp;
            end else if (roll_a) begin
                pin_o <= !pin_o;
            end
        end
    end

    // ---------------- interrupt flags, write one to clear
    logic [2:0] set_ev;
    logic [2:0] clr_ev;

    assign set_ev = {roll_b, cap_ev || cmp_ev, roll_a};
    assign clr_ev = (wr_go && wa == off_status && ws[0]) ? wd[2:0] : 3'h0;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= 3'h0;
        end else begin
            status <= (status & ~clr_ev) | set_ev;
        end
    end

    // next flags against the next mask, so irq never lags a mask write
    logic [2:0] next_status_m;
    assign next_status_m = ((status & ~clr_ev) | set_ev)
        & ((wr_go && wa == off_mask && ws[0]) ? wd[2:0] : mask);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status_m);
        end
    end

    // ---------------- checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    split_pin_a: assert property (split |=> !pin_oe)
        else $error("pin driven while split");
    irq_level_a: assert property (##1 irq == |(status & mask))
        else $error("interrupt does not follow flags");
    flag_hold_a: assert property (status[0] && !clr_ev[0] |=> status[0])
        else $error("rollover flag lost");
    one_shot_a: assert property (roll_a && !ctrl[bit_cont_a] && !wr_ctrl |=> !en_a)
        else $error("one-shot did not stop");
    reload_a: assert property (roll_a && !split && !wr_cnt |=> cnt == 32'h0)
        else $error("counter did not reload");
    split_keep_a: assert property (
        split && !step_b && !wr_cnt |=> $stable(cnt[31:16]))
        else $error("upper half moved without its enable");
    capture_a: assert property (cap_ev |=> capt == $past(cnt))
        else $error("capture value wrong");
    count_pin_a: assert property (
        !split && en_a && pmode == pin_count && !pin_rise |-> !step_a)
        else $error("counted without a pin edge");
    pwm_out_a: assert property (
        ##1 $past(pin_live && pmode == pin_pwm) |-> pin_o == $past(cnt < cmp))
        else $error("pwm level wrong");
    bresp_a: assert property (wr_go |=> s_axi_bvalid)
        else $error("write not answered");

    roll_c: cover property (roll_a && !split);
    split_c: cover property (roll_a ##[1:50] roll_b);
    capture_c: cover property (cap_ev);
    irq_c: cover property (!irq ##1 irq);
endmodule

// file: verification/tmr_pin_model.sv
// far side of the timer pin: external source that also sees the timer's drive
`timescale 1ns/100ps
module tmr_pin_model (
    input wire logic aclk,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pin_i
);
    logic drv = 1'b0;

    // the timer's drive wins while it owns the pin
    assign pin_i = pin_oe ? pin_o : drv;

    // high two cycles, low at least two: no faster than a quarter clock
    task pulse(input int n);
        repeat (n) begin
            @(posedge aclk);
            drv <= 1'b1;
            repeat (2) @(posedge aclk);
            drv <= 1'b0;
            @(posedge aclk);
        end
    endtask
endmodule

// file: verification/split_capable_timer_unit_tb.sv
// self-checking testbench for the split-capable timer
`timescale 1ns/100ps
module split_capable_timer_unit_tb;
    import tmr_pkg::*;
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [31:0] a;
    logic [31:0] b;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [1:0] wresp;
    logic [1:0] rresp_l;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic pin_i, pin_o, pin_oe, irq;
    int num_errors = 0;
    int compares = 0;
    int hi;
    int tog;
    int i;

    tmr_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .irq(irq));

    tmr_pin_model pin (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task test_done;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    task wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge aclk);
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        wresp = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] ad, output logic [31:0] dt);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        dt = rdata;
        rresp_l = rresp;
        rready <= 1'b0;
    endtask

    // fifty clock cycles of pin output: high cycles and transitions
    task watch;
        logic last;
        hi = 0;
        tog = 0;
        @(posedge aclk);
        last = pin_o;
        repeat (50) begin
            @(posedge aclk);
            if (pin_o === 1'b1) hi++;
            if (pin_o !== last) tog++;
            last = pin_o;
        end
    endtask

    task t_reset;
        rd(off_ctrl, d);
        chk(d === rst_ctrl, "ctrl reset value");
        chk(rresp_l === resp_okay, "mapped read response");
        rd(off_limit, d);
        chk(d === rst_limit, "limit reset value");
        rd(off_presc, d);
        chk(d === rst_presc, "prescaler reset value");
        rd(off_mask, d);
        chk(d[2:0] === rst_mask, "mask reset value");
        rd(8'h40, d);
        chk(rresp_l === resp_slverr, "unmapped read response");
        wr(8'h40, 32'h0000_0001);
        chk(wresp === resp_slverr, "unmapped write response");
    endtask

    task t_oneshot;
        wr(off_limit, 32'h0000_0003);
        chk(wresp === resp_okay, "mapped write response");
        wr(off_count, 32'h0000_0000);
        wr(off_status, 32'h0000_0007);
        wr(off_ctrl, 32'h0000_0001);
        i = 0;
        do begin
            rd(off_ctrl, d);
            i++;
        end while (d[bit_en_a] !== 1'b0 && i < 20);
        chk(d[bit_en_a] === 1'b0, "one-shot enable not cleared");
        rd(off_count, d);
        chk(d === 32'h0000_0000, "one-shot count not at zero");
        rd(off_status, d);
        chk(d[bit_roll_a] === 1'b1, "rollover flag missing");
        chk(irq === 1'b0, "irq while masked");
        wr(off_mask, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        chk(irq === 1'b1, "irq not raised");
        wr(off_status, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        chk(irq === 1'b0, "irq not cleared");
    endtask

    task t_pin_out;
        wr(off_ctrl, 32'h0000_0000);
        wr(off_limit, 32'h0000_0004);
        wr(off_cmp, 32'h0000_0002);
        wr(off_count, 32'h0000_0000);
        wr(off_status, 32'h0000_0007);
        // rollover output, continuous
        wr(off_ctrl, 32'h0000_0043);
        watch();
        chk(pin_oe === 1'b1, "pin not driven");
        chk(tog == 10, "rollover toggles");
        wr(off_ctrl, 32'h0000_0023);
        watch();
        chk(hi == 20, "pwm duty");
        rd(off_status, d);
        chk(d[bit_event] === 1'b1, "compare flag missing");
    endtask

    task t_split;
        wr(off_ctrl, 32'h0000_0000);
        wr(off_limit, 32'hffff_ffff);
        wr(off_presc, 32'h0003_0000);
        wr(off_count, 32'h0000_0000);
        // split, both halves on, pwm requested
        wr(off_ctrl, 32'h0000_003f);
        repeat (40) @(posedge aclk);
        chk(pin_oe === 1'b0, "pin driven in split mode");
        wr(off_ctrl, 32'h0000_0004);
        rd(off_count, d);
        a = {16'h0000, d[15:0]};
        b = {16'h0000, d[31:16]} << 2;
        chk(b !== 0 && a + 4 >= b && a <= b + 8, "split halves ratio");
        wr(off_presc, 32'h0000_0000);
        // both halves one-shot, each with its own limit
        wr(off_limit, 32'h0003_0002);
        wr(off_count, 32'h0000_0000);
        wr(off_status, 32'h0000_0007);
        wr(off_ctrl, 32'h0000_000d);
        repeat (10) @(posedge aclk);
        rd(off_status, d);
        chk(d[bit_roll_a] === 1'b1 && d[bit_roll_b] === 1'b1, "split rollover flags");
        rd(off_ctrl, d);
        chk(d[bit_en_a] === 1'b0 && d[bit_en_b] === 1'b0, "split one-shot enables");
    endtask

    task t_pin_in;
        wr(off_ctrl, 32'h0000_0000);
        wr(off_count, 32'h0000_0000);
        wr(off_ctrl, 32'h0000_0061);
        pin.pulse(5);
        repeat (4) @(posedge aclk);
        chk(pin_oe === 1'b0, "pin driven in input mode");
        rd(off_count, d);
        chk(d === 32'h0000_0005, "external count");
        wr(off_ctrl, 32'h0000_0000);
        wr(off_count, 32'h0000_0000);
        wr(off_ctrl, 32'h0000_0081);
        repeat (10) @(posedge aclk);
        rd(off_count, d);
        chk(d === 32'h0000_0000, "gated count moved");
        pin.pulse(1);
        repeat (4) @(posedge aclk);
        rd(off_count, d);
        chk(d === 32'h0000_0002, "gate open count");
        wr(off_ctrl, 32'h0000_0000);
        wr(off_status, 32'h0000_0007);
        wr(off_count, 32'h0000_0000);
        wr(off_ctrl, 32'h0000_00a1);
        repeat (8) @(posedge aclk);
        pin.pulse(1);
        repeat (4) @(posedge aclk);
        rd(off_status, d);
        chk(d[bit_event] === 1'b1, "capture flag missing");
        rd(off_capt, d);
        chk(d !== 32'h0000_0000, "capture value empty");
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        test_done();
    end

    initial begin
        aresetn = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_oneshot();
        t_pin_out();
        t_split();
        t_pin_in();
        test_done();
    end
endmodule
